// >>> inc/bts_defs.vh
// Register map, field positions, reset values and codes of the brake sequencer
`ifndef BTS_DEFS_VH
`define BTS_DEFS_VH
// Register byte offsets
`define BTS_OFF_CTRL 12'h000
`define BTS_OFF_RLS_CURR 12'h004
`define BTS_OFF_RLS_DLY 12'h008
`define BTS_OFF_RLS_FWD 12'h00C
`define BTS_OFF_RLS_REV 12'h010
`define BTS_OFF_ENG_FREQ 12'h014
`define BTS_OFF_ENG_DLY 12'h018
`define BTS_OFF_PREEXC 12'h01C
`define BTS_OFF_DC_TIME 12'h020
`define BTS_OFF_DC_LEVEL 12'h024
`define BTS_OFF_ONOFF_SRC 12'h028
`define BTS_OFF_ON_LEVEL 12'h02C
`define BTS_OFF_OFF_LEVEL 12'h030
`define BTS_OFF_OUT_FUNC 12'h034
`define BTS_OFF_STATUS 12'h038
// Control register fields
`define BTS_CTRL_BRK_EN 0
`define BTS_CTRL_VECTOR 1
`define BTS_CTRL_TORQUE 2
// Reset values (frequencies in 0.01 Hz, currents and levels in 0.01 %,
// delays in ms)
`define BTS_RST_RLS_CURR 16'h1388
`define BTS_RST_RLS_DLY 16'h03E8
`define BTS_RST_RLS_FWD 16'h0064
`define BTS_RST_RLS_REV 16'h0064
`define BTS_RST_ENG_FREQ 16'h00C8
`define BTS_RST_ENG_DLY 16'h03E8
`define BTS_RST_PREEXC 16'h0064
`define BTS_RST_ONOFF_SRC 3'h1
`define BTS_RST_ON_LEVEL 16'h2328
`define BTS_RST_OFF_LEVEL 16'h03E8
`define BTS_ON_LEVEL_MIN 16'h03E8
`define BTS_ON_LEVEL_MAX 16'h2710
`define BTS_SRC_MAX 3'h4
// Output function codes
`define BTS_FUNC_ONOFF 8'h22
`define BTS_FUNC_BRAKE 8'h23
`define BTS_NUM_OUTS 3
// Timing: 1 ms tick at 100 MHz
`define BTS_CLK_MHZ 100
`define BTS_TICK_US 1000
`define BTS_TICK_CYC (`BTS_CLK_MHZ * `BTS_TICK_US)
`define BTS_TICK_LAST 17'h1_869F
`endif

// >>> verilog/bts_hold_timer.v
// Millisecond down-counter used for every hold delay of the sequencer
`timescale 1ns/1ns
`default_nettype none
module bts_hold_timer (
  input wire clk_i,           // System clock
  input wire rst_n_i,         // Async reset, active low
  input wire tick_i,          // One-cycle 1 ms enable
  input wire start_i,         // Load the count
  input wire [15:0] load_i,   // Delay in ms
  output wire done_o          // High when the count is exhausted
);
  reg [15:0] count;
  reg busy;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else if (start_i) begin
      count <= load_i;
      busy <= 1'b1;
    end else if (busy && (count == 16'h0000)) begin
      busy <= 1'b0;
    end else if (busy && tick_i) begin
      count <= count - 16'h0001;
    end
  end
  // A zero load ends the cycle after the start; the tick is shared, so a
  // nonzero delay may end up to 1 ms early rather than 1 ms late
  assign done_o = busy && (count == 16'h0000);
endmodule // bts_hold_timer
`default_nettype wire

// >>> verilog/bts_sequencer.v
// Brake release/engage sequencer and analog on/off output with AHB-Lite regs
`timescale 1ns/1ns
`default_nettype none
`include "bts_defs.vh"
module bts_sequencer (
  input wire SYS_CLK_I,            // 100 MHz clock
  input wire RST_N_I,              // Async reset, active low
  input wire [31:0] HADDR_I,       // AHB address
  input wire [1:0] HTRANS_I,       // AHB transfer type
  input wire HWRITE_I,             // AHB write
  input wire [2:0] HSIZE_I,        // AHB size
  input wire [31:0] HWDATA_I,      // AHB write data
  input wire HSEL_I,               // AHB slave select
  input wire HREADY_I,             // AHB bus ready
  output wire [31:0] HRDATA_O,     // AHB read data
  output wire HREADYOUT_O,         // AHB slave ready
  output wire HRESP_O,             // AHB response, always OKAY
  input wire RUN_CMD_I,            // Run command level
  input wire DIR_REV_I,            // Commanded direction, 1 = reverse
  input wire [15:0] OUT_FREQ_I,    // Actual output frequency, 0.01 Hz
  input wire [15:0] MOTOR_CURR_I,  // Motor current, 0.01 %
  input wire [15:0] ANALOG0_I,     // Analog source 0, 0.01 %
  input wire [15:0] ANALOG1_I,     // Analog source 1 (voltage input one)
  input wire [15:0] ANALOG2_I,     // Analog source 2
  input wire [15:0] ANALOG3_I,     // Analog source 3
  input wire [15:0] ANALOG4_I,     // Analog source 4
  output reg [15:0] FREQ_TARGET_O, // Frequency target to the ramp
  output reg FREQ_HOLD_O,          // Freeze the ramp at current value
  output reg RAMP_EN_O,            // Normal acceleration allowed
  output reg DC_INJECT_O,          // Apply stop DC injection
  output reg OUT_BLOCK_O,          // Block inverter output
  output reg START_DC_INHIBIT_O,   // Suppress start DC injection
  output reg DWELL_INHIBIT_O,      // Suppress acc/dec dwell
  output reg BRAKE_RELEASE_O,      // Brake release (0 = engaged)
  output reg ONOFF_STATE_O,        // Threshold output state
  output reg [2:0] RELAY_OUT_O     // Relay 1, relay 2, open collector one
);
  localparam ST_IDLE = 4'd0;
  localparam ST_PREEXC = 4'd1;
  localparam ST_TO_RLS = 4'd2;
  localparam ST_WAIT_CURR = 4'd3;
  localparam ST_RLS_HOLD = 4'd4;
  localparam ST_RUN = 4'd5;
  localparam ST_DECEL = 4'd6;
  localparam ST_ENG_HOLD = 4'd7;
  localparam ST_DC = 4'd8;
  localparam ST_BLOCK = 4'd9;
  localparam [16:0] TICK_LAST = `BTS_TICK_LAST;

  reg [2:0] ctrl;
  reg [15:0] rls_curr, rls_dly, rls_fwd, rls_rev, eng_freq, eng_dly;
  reg [15:0] preexc, dc_time, dc_level, on_level, off_level;
  reg [2:0] onoff_src;
  reg [7:0] out_func [0:`BTS_NUM_OUTS-1];
  reg [3:0] state, next_state;
  reg [16:0] tick_cnt;
  reg tick;
  reg tmr_start;
  reg [15:0] tmr_load;
  wire tmr_done;

  // Bus address phase capture
  reg dp_wr, dp_rd;
  reg [11:0] dp_addr;
  reg [31:0] rdata;
  wire take = HSEL_I && HREADY_I && HTRANS_I[1];
  wire brk_en = ctrl[`BTS_CTRL_BRK_EN];
  wire vector = ctrl[`BTS_CTRL_VECTOR];
  wire torque = ctrl[`BTS_CTRL_TORQUE];
  wire [15:0] rls_freq = DIR_REV_I ? rls_rev : rls_fwd;
  wire dc_cfg = (dc_time != 16'h0000) && (dc_level != 16'h0000);
  // On level is clamped to 10..100 %
  wire [15:0] on_wr =
    (HWDATA_I[15:0] < `BTS_ON_LEVEL_MIN) ? `BTS_ON_LEVEL_MIN :
    (HWDATA_I[15:0] > `BTS_ON_LEVEL_MAX) ? `BTS_ON_LEVEL_MAX :
    HWDATA_I[15:0];
  integer i;
  integer j;

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata;

  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 12'h000;
    end else if (HREADY_I) begin
      dp_wr <= take && HWRITE_I;
      dp_rd <= take && !HWRITE_I;
      dp_addr <= HADDR_I[11:0];
    end
  end

  // Writes land in the data phase, when HWDATA is valid
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= 3'h0;
      rls_curr <= `BTS_RST_RLS_CURR;
      rls_dly <= `BTS_RST_RLS_DLY;
      rls_fwd <= `BTS_RST_RLS_FWD;
      rls_rev <= `BTS_RST_RLS_REV;
      eng_freq <= `BTS_RST_ENG_FREQ;
      eng_dly <= `BTS_RST_ENG_DLY;
      preexc <= `BTS_RST_PREEXC;
      dc_time <= 16'h0000;
      dc_level <= 16'h0000;
      onoff_src <= `BTS_RST_ONOFF_SRC;
      on_level <= `BTS_RST_ON_LEVEL;
      off_level <= `BTS_RST_OFF_LEVEL;
      for (i = 0; i < `BTS_NUM_OUTS; i = i + 1) begin
        out_func[i] <= 8'h00;
      end
    end else if (dp_wr) begin
      case (dp_addr)
        `BTS_OFF_CTRL: ctrl <= HWDATA_I[2:0];
        `BTS_OFF_RLS_CURR: rls_curr <= HWDATA_I[15:0];
        `BTS_OFF_RLS_DLY: rls_dly <= HWDATA_I[15:0];
        `BTS_OFF_RLS_FWD: rls_fwd <= HWDATA_I[15:0];
        `BTS_OFF_RLS_REV: rls_rev <= HWDATA_I[15:0];
        `BTS_OFF_ENG_FREQ: eng_freq <= HWDATA_I[15:0];
        `BTS_OFF_ENG_DLY: eng_dly <= HWDATA_I[15:0];
        `BTS_OFF_PREEXC: preexc <= HWDATA_I[15:0];
        `BTS_OFF_DC_TIME: dc_time <= HWDATA_I[15:0];
        `BTS_OFF_DC_LEVEL: dc_level <= HWDATA_I[15:0];
        `BTS_OFF_ONOFF_SRC: begin
          // Out-of-range codes are ignored
          if (HWDATA_I[2:0] <= `BTS_SRC_MAX && HWDATA_I[31:3] == 29'h0)
            onoff_src <= HWDATA_I[2:0];
        end
        `BTS_OFF_ON_LEVEL: begin
          // Off level follows a clamped on level down
          on_level <= on_wr;
          if (off_level > on_wr) begin
            off_level <= on_wr;
          end
        end
        `BTS_OFF_OFF_LEVEL: begin
          if (HWDATA_I[15:0] > on_level) begin
            off_level <= on_level;
          end else begin
            off_level <= HWDATA_I[15:0];
          end
        end
        `BTS_OFF_OUT_FUNC: begin
          out_func[0] <= HWDATA_I[7:0];
          out_func[1] <= HWDATA_I[15:8];
          out_func[2] <= HWDATA_I[23:16];
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata <= 32'h0000_0000;
    end else if (take && !HWRITE_I) begin
      case (HADDR_I[11:0])
        `BTS_OFF_CTRL: rdata <= {29'h0, ctrl};
        `BTS_OFF_RLS_CURR: rdata <= {16'h0000, rls_curr};
        `BTS_OFF_RLS_DLY: rdata <= {16'h0000, rls_dly};
        `BTS_OFF_RLS_FWD: rdata <= {16'h0000, rls_fwd};
        `BTS_OFF_RLS_REV: rdata <= {16'h0000, rls_rev};
        `BTS_OFF_ENG_FREQ: rdata <= {16'h0000, eng_freq};
        `BTS_OFF_ENG_DLY: rdata <= {16'h0000, eng_dly};
        `BTS_OFF_PREEXC: rdata <= {16'h0000, preexc};
        `BTS_OFF_DC_TIME: rdata <= {16'h0000, dc_time};
        `BTS_OFF_DC_LEVEL: rdata <= {16'h0000, dc_level};
        `BTS_OFF_ONOFF_SRC: rdata <= {29'h0, onoff_src};
        `BTS_OFF_ON_LEVEL: rdata <= {16'h0000, on_level};
        `BTS_OFF_OFF_LEVEL: rdata <= {16'h0000, off_level};
        `BTS_OFF_OUT_FUNC:
          rdata <= {8'h00, out_func[2], out_func[1], out_func[0]};
        `BTS_OFF_STATUS:
          rdata <= {24'h0, ONOFF_STATE_O, BRAKE_RELEASE_O, 2'b00, state};
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // 1 ms enable for all hold delays
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 17'h0_0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= 17'h0_0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h0_0001;
      tick <= 1'b0;
    end
  end

  bts_hold_timer u_timer (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .tick_i(tick),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .done_o(tmr_done)
  );

  always @* begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_load = 16'h0000;
    case (state)
      ST_IDLE: begin
        if (brk_en && RUN_CMD_I) begin
          if (vector) begin
            next_state = ST_PREEXC;
            tmr_start = 1'b1;
            tmr_load = preexc;
          end else begin
            next_state = ST_TO_RLS;
          end
        end
      end
      ST_PREEXC: begin
        if (!RUN_CMD_I) begin
          next_state = ST_IDLE;
        end else if (tmr_done) begin
          next_state = ST_RLS_HOLD;
          tmr_start = 1'b1;
          tmr_load = rls_dly;
        end
      end
      ST_TO_RLS: begin
        if (!RUN_CMD_I) begin
          next_state = ST_IDLE;
        end else if (OUT_FREQ_I >= rls_freq) begin
          next_state = ST_WAIT_CURR;
        end
      end
      ST_WAIT_CURR: begin
        if (!RUN_CMD_I) begin
          next_state = ST_IDLE;
        end else if (MOTOR_CURR_I >= rls_curr) begin
          next_state = ST_RLS_HOLD;
          tmr_start = 1'b1;
          tmr_load = rls_dly;
        end
      end
      ST_RLS_HOLD: begin
        if (tmr_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!RUN_CMD_I && !torque) begin
          next_state = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (RUN_CMD_I) begin
          next_state = ST_RUN;
        end else if (vector ? (OUT_FREQ_I == 16'h0000)
                            : (OUT_FREQ_I <= eng_freq)) begin
          next_state = ST_ENG_HOLD;
          tmr_start = 1'b1;
          tmr_load = eng_dly;
        end
      end
      ST_ENG_HOLD: begin
        if (tmr_done) begin
          if (vector) begin
            next_state = ST_BLOCK;
          end else if (dc_cfg && OUT_FREQ_I == 16'h0000) begin
            next_state = ST_DC;
            tmr_start = 1'b1;
            tmr_load = dc_time;
          end else if (!dc_cfg) begin
            next_state = ST_BLOCK;
          end
        end else if (!vector && dc_cfg && OUT_FREQ_I == 16'h0000 &&
                     FREQ_TARGET_O == 16'h0000) begin
          next_state = ST_DC;
          tmr_start = 1'b1;
          tmr_load = dc_time;
        end
      end
      ST_DC: begin
        if (tmr_done) begin
          next_state = ST_BLOCK;
        end
      end
      ST_BLOCK: begin
        if (!RUN_CMD_I) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Turning brake control off abandons the sequence safely
    if (!brk_en) begin
      next_state = ST_IDLE;
      tmr_start = 1'b0;
    end
  end

  // After the engage delay the hold is released, so the frequency ramps to the zero target
  reg eng_elapsed;
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      eng_elapsed <= 1'b0;
    end else begin
      state <= next_state;
      if (state != ST_ENG_HOLD) begin
        eng_elapsed <= 1'b0;
      end else if (tmr_done) begin
        eng_elapsed <= 1'b1;
      end
    end
  end

  wire [15:0] sel_analog = (onoff_src == 3'd0) ? ANALOG0_I :
                           (onoff_src == 3'd1) ? ANALOG1_I :
                           (onoff_src == 3'd2) ? ANALOG2_I :
                           (onoff_src == 3'd3) ? ANALOG3_I :
                           ANALOG4_I;

  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FREQ_TARGET_O <= 16'h0000;
      FREQ_HOLD_O <= 1'b0;
      RAMP_EN_O <= 1'b0;
      DC_INJECT_O <= 1'b0;
      OUT_BLOCK_O <= 1'b1;
      START_DC_INHIBIT_O <= 1'b0;
      DWELL_INHIBIT_O <= 1'b0;
      BRAKE_RELEASE_O <= 1'b0;
      ONOFF_STATE_O <= 1'b0;
      RELAY_OUT_O <= 3'b000;
    end else begin
      START_DC_INHIBIT_O <= brk_en;
      DWELL_INHIBIT_O <= brk_en;
      FREQ_TARGET_O <= (next_state == ST_TO_RLS ||
                        next_state == ST_WAIT_CURR ||
                        (next_state == ST_RLS_HOLD && !vector)) ?
                       rls_freq : 16'h0000;
      FREQ_HOLD_O <= (next_state == ST_WAIT_CURR) ||
                     (next_state == ST_RLS_HOLD && !vector) ||
                     (next_state == ST_ENG_HOLD && !vector &&
                      !eng_elapsed && !tmr_done);
      RAMP_EN_O <= (next_state == ST_RUN) ||
                   (next_state == ST_DECEL);
      DC_INJECT_O <= (next_state == ST_DC);
      OUT_BLOCK_O <= (next_state == ST_IDLE) || (next_state == ST_PREEXC) ||
                     (next_state == ST_BLOCK);
      BRAKE_RELEASE_O <= (next_state == ST_RLS_HOLD) ||
                         (next_state == ST_RUN) ||
                         (next_state == ST_DECEL);
      if (sel_analog > on_level) begin
        ONOFF_STATE_O <= 1'b1;
      end else if (sel_analog < off_level) begin
        ONOFF_STATE_O <= 1'b0;
      end
      // Otherwise hold the previous state
      for (j = 0; j < `BTS_NUM_OUTS; j = j + 1) begin
        if (out_func[j] == `BTS_FUNC_ONOFF) begin
          RELAY_OUT_O[j] <= ONOFF_STATE_O;
        end else if (out_func[j] == `BTS_FUNC_BRAKE) begin
          RELAY_OUT_O[j] <= BRAKE_RELEASE_O;
        end else begin
          RELAY_OUT_O[j] <= 1'b0;
        end
      end
    end
  end
endmodule // bts_sequencer
`default_nettype wire

// >>> sim/bts_load_model.sv
// Behavioural motor load: output frequency ramps toward the sequencer's goal
`timescale 1ns/1ns
`default_nettype none
module bts_load_model (
  input wire logic clk_i,            // Clock
  input wire logic rst_n_i,          // Reset, active low
  input wire logic [15:0] ref_i,     // Speed reference for the normal ramp
  input wire logic [15:0] target_i,  // Target during release phases
  input wire logic hold_i,           // Freeze the frequency
  input wire logic ramp_en_i,        // Follow the reference
  input wire logic block_i,          // Output blocked
  output logic [15:0] freq_o         // Actual output frequency
);
  logic [15:0] goal;
  assign goal = ramp_en_i ? ref_i : target_i;
  // Goals are kept multiples of the step, so the ramp lands exactly on them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      freq_o <= 16'h0000;
    else if (block_i)
      freq_o <= 16'h0000;
    else if (hold_i)
      freq_o <= freq_o;
    else if (freq_o < goal)
      freq_o <= freq_o + 16'h0004;
    else if (freq_o > goal)
      freq_o <= freq_o - 16'h0004;
  end
endmodule // bts_load_model
`default_nettype wire

// >>> sim/bts_sequencer_sva.sv
// Port-level assertions for the brake and threshold sequencer
`timescale 1ns/1ns
`default_nettype none
module bts_sequencer_sva (
  input wire logic SYS_CLK_I,           // Clock
  input wire logic RST_N_I,             // Reset, active low
  input wire logic [15:0] OUT_FREQ_I,   // Actual frequency
  input wire logic [15:0] ANALOG0_I,    // Analog 0
  input wire logic [15:0] ANALOG1_I,    // Analog 1
  input wire logic [15:0] ANALOG2_I,    // Analog 2
  input wire logic [15:0] ANALOG3_I,    // Analog 3
  input wire logic [15:0] ANALOG4_I,    // Analog 4
  input wire logic HREADYOUT_O,         // Bus ready
  input wire logic HRESP_O,             // Bus response
  input wire logic [15:0] FREQ_TARGET_O, // Frequency target
  input wire logic FREQ_HOLD_O,         // Ramp hold
  input wire logic RAMP_EN_O,           // Ramp enable
  input wire logic DC_INJECT_O,         // Stop DC injection
  input wire logic OUT_BLOCK_O,         // Output block
  input wire logic START_DC_INHIBIT_O,  // Start DC suppressed
  input wire logic DWELL_INHIBIT_O,     // Dwell suppressed
  input wire logic BRAKE_RELEASE_O,     // Brake release
  input wire logic ONOFF_STATE_O,       // Threshold output
  input wire logic [2:0] RELAY_OUT_O    // Relay outputs
);
  // Only valid while the engage frequency keeps its reset value
  localparam logic [15:0] ENG_FREQ = 16'h00C8;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  bus_okay_a: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus slave not ready or not okay");
  inhibit_brake_a: assert property (
    BRAKE_RELEASE_O |-> START_DC_INHIBIT_O && DWELL_INHIBIT_O)
    else $error("release without start dc and dwell suppressed");
  release_hold_a: assert property (
    $rose(BRAKE_RELEASE_O) |->
      !RAMP_EN_O && (FREQ_HOLD_O || OUT_FREQ_I == 16'h0000))
    else $error("release without frequency hold");
  engage_freq_a: assert property (
    $fell(BRAKE_RELEASE_O) && !OUT_BLOCK_O |-> $past(OUT_FREQ_I) <= ENG_FREQ)
    else $error("engage above engage frequency");
  dc_zero_a: assert property (
    $rose(DC_INJECT_O) |-> $past(OUT_FREQ_I) == 16'h0000)
    else $error("dc injection before zero frequency");
  dc_block_a: assert property ($fell(DC_INJECT_O) |-> OUT_BLOCK_O)
    else $error("no output block after dc injection");
  ramp_target_a: assert property (
    RAMP_EN_O |-> FREQ_TARGET_O == 16'h0000)
    else $error("release target during normal ramp");
  idle_engaged_a: assert property (OUT_BLOCK_O |-> !BRAKE_RELEASE_O)
    else $error("brake released while output blocked");
  relay_src_a: assert property (
    |RELAY_OUT_O |-> $past(ONOFF_STATE_O) || $past(BRAKE_RELEASE_O))
    else $error("relay on without a source");
  onoff_rise_a: assert property ($rose(ONOFF_STATE_O) |->
    $past(ANALOG0_I) > 16'h03E8 || $past(ANALOG1_I) > 16'h03E8 ||
    $past(ANALOG2_I) > 16'h03E8 || $past(ANALOG3_I) > 16'h03E8 ||
    $past(ANALOG4_I) > 16'h03E8)
    else $error("threshold output on with all inputs low");
  reset_state_a: assert property ($rose(RST_N_I) |->
    OUT_BLOCK_O && !BRAKE_RELEASE_O && !ONOFF_STATE_O && RELAY_OUT_O == 3'h0)
    else $error("outputs not idle after reset");
endmodule // bts_sequencer_sva
`default_nettype wire

// >>> sim/bts_sequencer_test.sv
// Self-checking bench for the brake and threshold output sequencer
`timescale 1ns/1ns
`default_nettype none
`include "bts_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module bts_sequencer_test;
  logic clk, rst_n, hwrite, hsel, run, dir;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [15:0] ref_f, cur;
  logic [15:0] an [5];
  wire [31:0] hrdata;
  wire [15:0] tgt, freq;
  wire [2:0] relay;
  wire hready, hresp, hold, ramp, dc, blk, sdi, dwi, rel, onoff;
  wire [4:0] io = {rel, hold, ramp, dc, blk}; // Brake-side outputs
  int fail_count, check_count;
  bts_sequencer i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HSEL_I(hsel), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .RUN_CMD_I(run), .DIR_REV_I(dir), .OUT_FREQ_I(freq),
    .MOTOR_CURR_I(cur), .ANALOG0_I(an[0]), .ANALOG1_I(an[1]),
    .ANALOG2_I(an[2]), .ANALOG3_I(an[3]), .ANALOG4_I(an[4]),
    .FREQ_TARGET_O(tgt), .FREQ_HOLD_O(hold), .RAMP_EN_O(ramp),
    .DC_INJECT_O(dc), .OUT_BLOCK_O(blk), .START_DC_INHIBIT_O(sdi),
    .DWELL_INHIBIT_O(dwi), .BRAKE_RELEASE_O(rel), .ONOFF_STATE_O(onoff),
    .RELAY_OUT_O(relay));
  bts_load_model i_load (.clk_i(clk), .rst_n_i(rst_n), .ref_i(ref_f),
    .target_i(tgt), .hold_i(hold), .ramp_en_i(ramp), .block_i(blk),
    .freq_o(freq));
  task automatic ahb_wr(input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic ahb_rd(input logic [11:0] a, output logic [31:0] d);
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  // Polls the status state field; a lost sequence shows as a wrong state
  task automatic wait_st(input logic [3:0] s);
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      ahb_rd(`BTS_OFF_STATUS, d);
      n++;
    end while (d[3:0] !== s && n < 60000);
    `CHK("state", s, d[3:0])
    #1;
  endtask
  // Per-cycle wait on the outputs, for states that last a single cycle
  task automatic wait_io(input logic [4:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (io !== e && n < 120000);
    `CHK("outputs", e, io)
  endtask
  task automatic step;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (130000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    logic [15:0] rv [16];
    logic [15:0] tv [7];
    logic [6:0] te;
    logic [31:0] d;
    int i, j, k;
    rv = '{16'h0000, 16'h1388, 16'h03E8, 16'h0064, 16'h0064, 16'h00C8,
      16'h03E8, 16'h0064, 16'h0000, 16'h0000, 16'h0001, 16'h2328, 16'h03E8,
      16'h0000, 16'h0000, 16'h0000};
    tv = '{16'h01F4, 16'h251C, 16'h03E8, 16'h03E7, 16'h2328, 16'h2329,
      16'h01F4};
    te = 7'h26;
    rst_n = 1'b0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsel = 1'b0;
    run = 1'b0;
    dir = 1'b0;
    ref_f = 16'h0000;
    cur = 16'h0000;
    for (j = 0; j < 5; j++) an[j] = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("block", 1'b1, blk)
    for (i = 0; i < 16; i++) begin
      ahb_rd(12'(i * 4), d);
      `CHK("reg", {16'h0000, rv[i]}, d)
    end
    $display("test reset values done");
    // Unselected inputs take 16'h2710 minus the selected value, so a wrong source shows
    ahb_wr(`BTS_OFF_OUT_FUNC, 32'h0022_2322);
    for (i = 0; i < 5; i++) begin
      ahb_wr(`BTS_OFF_ONOFF_SRC, 32'(i));
      for (k = 0; k < 7; k++) begin
        for (j = 0; j < 5; j++) an[j] <= (j == i) ? tv[k] : 16'h2710 - tv[k];
        step;
        `CHK("onoff", te[k], onoff)
        `CHK("relay", {te[k], 1'b0, te[k]}, relay)
      end
    end
    ahb_wr(`BTS_OFF_ONOFF_SRC, 32'h0000_0005);
    ahb_rd(`BTS_OFF_ONOFF_SRC, d);
    `CHK("src", 32'h0000_0004, d)
    ahb_wr(`BTS_OFF_ON_LEVEL, 32'h0000_4E20);
    ahb_rd(`BTS_OFF_ON_LEVEL, d);
    `CHK("on", 32'h0000_2710, d)
    ahb_wr(`BTS_OFF_OFF_LEVEL, 32'h0000_1F40);
    ahb_wr(`BTS_OFF_ON_LEVEL, 32'h0000_01F4);
    ahb_rd(`BTS_OFF_ON_LEVEL, d);
    `CHK("on", 32'h0000_03E8, d)
    ahb_rd(`BTS_OFF_OFF_LEVEL, d);
    `CHK("off", 32'h0000_03E8, d)
    ahb_wr(`BTS_OFF_OFF_LEVEL, 32'h0000_2000);
    ahb_rd(`BTS_OFF_OFF_LEVEL, d);
    `CHK("off", 32'h0000_03E8, d)
    $display("test threshold output done");
    ahb_wr(`BTS_OFF_RLS_DLY, 32'h0000_0000);
    ahb_wr(`BTS_OFF_ENG_DLY, 32'h0000_0000);
    ahb_wr(`BTS_OFF_PREEXC, 32'h0000_0000);
    ahb_wr(`BTS_OFF_DC_TIME, 32'h0000_0001);
    ahb_wr(`BTS_OFF_DC_LEVEL, 32'h0000_0001);
    ahb_wr(`BTS_OFF_RLS_REV, 32'h0000_012C);
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0001);
    step;
    `CHK("inhibit", 2'h3, {sdi, dwi})
    dir <= 1'b1;
    run <= 1'b1;
    wait_st(4'h3);
    `CHK("target", 16'h012C, tgt)
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0000);
    wait_st(4'h0);
    run <= 1'b0;
    dir <= 1'b0;
    ref_f <= 16'h01F4;
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0001);
    run <= 1'b1;
    wait_st(4'h3);
    `CHK("target", 16'h0064, tgt)
    `CHK("release", 1'b0, rel)
    cur <= 16'h1770;
    wait_io(5'h18);
    `CHK("release", 2'h3, {rel, hold})
    wait_st(4'h5);
    `CHK("run", 2'h3, {ramp, relay[1]})
    run <= 1'b0;
    ref_f <= 16'h0000;
    wait_io(5'h08);
    `CHK("release", 1'b0, rel)
    wait_st(4'h8);
    `CHK("dc", 1'b1, dc)
    wait_io(5'h01);
    `CHK("block", 1'b1, blk)
    wait_st(4'h0);
    $display("test standard sequence done");
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0003);
    ref_f <= 16'h01F4;
    run <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("release", 2'h1, {rel, blk})
    wait_io(5'h10);
    `CHK("release", 2'h2, {rel, ramp})
    wait_st(4'h5);
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0007);
    run <= 1'b0;
    ref_f <= 16'h0000;
    repeat (50) @(posedge clk);
    wait_st(4'h5);
    `CHK("release", 1'b1, rel)
    ahb_wr(`BTS_OFF_CTRL, 32'h0000_0003);
    wait_io(5'h00);
    `CHK("release", 1'b0, rel)
    wait_io(5'h01);
    `CHK("block", 1'b1, blk)
    wait_st(4'h0);
    $display("test vector sequence done");
    close_out;
  end
endmodule // bts_sequencer_test
bind bts_sequencer bts_sequencer_sva i_sva (.SYS_CLK_I, .RST_N_I, .OUT_FREQ_I,
  .ANALOG0_I, .ANALOG1_I, .ANALOG2_I, .ANALOG3_I, .ANALOG4_I, .HREADYOUT_O,
  .HRESP_O, .FREQ_TARGET_O, .FREQ_HOLD_O, .RAMP_EN_O, .DC_INJECT_O,
  .OUT_BLOCK_O, .START_DC_INHIBIT_O, .DWELL_INHIBIT_O, .BRAKE_RELEASE_O,
  .ONOFF_STATE_O, .RELAY_OUT_O);
`default_nettype wire
